// ---- design/timer_pkg.sv ----
package timer_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 6;

   // Register indices, byte address is index times four
   localparam logic [IDX_W-1:0] IDX_CTRL_A   = 6'h00;
   localparam logic [IDX_W-1:0] IDX_CTRL_B   = 6'h01;
   localparam logic [IDX_W-1:0] IDX_COUNT_L  = 6'h02;
   localparam logic [IDX_W-1:0] IDX_COUNT_H  = 6'h03;
   localparam logic [IDX_W-1:0] IDX_CMP_A_L  = 6'h04;
   localparam logic [IDX_W-1:0] IDX_CMP_A_H  = 6'h05;
   localparam logic [IDX_W-1:0] IDX_CMP_B_L  = 6'h06;
   localparam logic [IDX_W-1:0] IDX_CMP_B_H  = 6'h07;
   localparam logic [IDX_W-1:0] IDX_CAP_L    = 6'h08;
   localparam logic [IDX_W-1:0] IDX_CAP_H    = 6'h09;
   localparam logic [IDX_W-1:0] IDX_FLAGS    = 6'h0A;
   localparam logic [IDX_W-1:0] IDX_MASK     = 6'h0B;
   localparam logic [IDX_W-1:0] IDX_MISC     = 6'h0C;

   // Field positions in control_reg_a
   localparam int CA_WGM_LSB = 0;
   localparam int CA_COMB_LSB = 4;
   localparam int CA_COMA_LSB = 6;
   // Field positions in control_reg_b
   localparam int CB_CS_LSB  = 0;
   localparam int CB_WGM_LSB = 3;
   localparam int CB_EDGE    = 6;
   localparam int CB_NOISE   = 7;
   // Flag and mask bit positions
   localparam int FL_OVF = 0;
   localparam int FL_MA  = 1;
   localparam int FL_MB  = 2;
   localparam int FL_CAP = 3;
   // Misc register bits
   localparam int MS_POWER_OFF = 0;
   localparam int MS_SRC_COMP  = 1;

   // Reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic        RST_POWER_OFF = 1'b0;

   // Counter limits
   localparam logic [15:0] BOTTOM_VAL = 16'h0000;
   localparam logic [15:0] MAX_VAL    = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT   = 16'h00FF;
   localparam logic [15:0] TOP_9BIT   = 16'h01FF;
   localparam logic [15:0] TOP_10BIT  = 16'h03FF;

   // Waveform generation modes
   localparam logic [3:0] WGM_NORMAL   = 4'h0;
   localparam logic [3:0] WGM_FAST8    = 4'h5;
   localparam logic [3:0] WGM_FAST9    = 4'h6;
   localparam logic [3:0] WGM_FAST10   = 4'h7;
   localparam logic [3:0] WGM_CTC_CMPA = 4'h4;
   localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
   localparam logic [3:0] WGM_FAST_CAP = 4'hE;
   localparam logic [3:0] WGM_FAST_CMPA = 4'hF;

   // Clock select codes
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIV1     = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam int         PRE_W       = 10;

   // Compare output actions
   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   // Capture filter length in samples
   localparam int FILTER_LEN = 4;

endpackage

// ---- design/edge_if.sv ----
`timescale 1ns/10ps
interface edge_if;
   logic noise_en;
   logic cap_rise;
   logic ext_rise;
   logic src_comp;
   logic cap_evt;
   logic ext_tick;

   modport core  (output noise_en, output cap_rise, output ext_rise, output src_comp,
                  input cap_evt, input ext_tick);
   modport front (input noise_en, input cap_rise, input ext_rise, input src_comp,
                  output cap_evt, output ext_tick);
endinterface

// ---- design/edge_front.sv ----
`timescale 1ns/10ps
module edge_front
   import timer_pkg::*;
#(
   parameter int FLT_LEN = timer_pkg::FILTER_LEN
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins
   input wire logic cap_pin,
   input wire logic comp_out,
   input wire logic ext_pin,
   // Core side
   edge_if.front    ev
);

   typedef struct packed {
      logic [2:0]         sync1;
      logic [2:0]         sync2;
      logic [FLT_LEN-1:0] hist;
      logic               level;
      logic               ext_prev;
      logic               cap_evt;
      logic               ext_tick;
   } front_state_t;

   front_state_t st_reg;
   front_state_t st_next;

   assign ev.cap_evt  = st_reg.cap_evt;
   assign ev.ext_tick = st_reg.ext_tick;

   always_comb begin
      logic raw;
      logic lvl;
      raw = 1'b0;
      lvl = 1'b0;
      st_next = st_reg;
      st_next.sync1 = {ext_pin, comp_out, cap_pin};
      st_next.sync2 = st_reg.sync1;
      // Source switch may itself look like an edge; software clears the flag after it
      raw = ev.src_comp ? st_reg.sync2[1] : st_reg.sync2[0];
      st_next.hist = {st_reg.hist[FLT_LEN-2:0], raw};
      // Filter costs FLT_LEN cycles of latency but rejects shorter spikes
      if (!ev.noise_en) begin
         lvl = raw;
      end else if (&st_reg.hist) begin
         lvl = 1'b1;
      end else if (~|st_reg.hist) begin
         lvl = 1'b0;
      end else begin
         lvl = st_reg.level;
      end
      st_next.level = lvl;
      st_next.cap_evt = (lvl != st_reg.level) && (lvl == ev.cap_rise);
      st_next.ext_prev = st_reg.sync2[2];
      st_next.ext_tick = (st_reg.sync2[2] != st_reg.ext_prev)
                         && (st_reg.sync2[2] == ev.ext_rise);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule

// ---- design/timer16.sv ----
// Function
// - One shared 8-bit high-byte holding register
// - Low-byte access alone launches wide transfer
// - Low write loads holding plus low byte
// - Low read copies upper byte into holding
// - High-byte location accesses holding register
// - Compare reads return bytes directly, holding untouched
// - Bottom signalled when counter becomes zero
// - Maximum reached when counter becomes all ones
// - Top is fixed value, compare A or capture
// - Clock select picks prescaler or external edge
// - No clock source selected holds counter
// - Software counter write beats clear or count
// - Both compares matched continuously, set flags
// - Qualifying trigger edge stores counter into capture, except while capture sets top
// - Selectable noise filter on capture trigger
// - Compare A as top: no PWM on channel A, buffered only in fast PWM
// - Four flags, each with its own mask
// - Control registers accessed directly, no holding
// - Capture flag set with capture register load
`timescale 1ns/10ps
module timer16
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic                          REF_CLK,
   input  wire logic                          RSTN,
   // APB slave
   input  wire logic                          PSEL,
   input  wire logic                          PENABLE,
   input  wire logic                          PWRITE,
   input  wire logic [timer_pkg::ADDR_W-1:0]  PADDR,
   input  wire logic [timer_pkg::DATA_W-1:0]  PWDATA,
   output logic      [timer_pkg::DATA_W-1:0]  PRDATA,
   output logic                               PREADY,
   output logic                               PSLVERR,
   // Timer pins
   input  wire logic                          CAPTURE_PIN,
   input  wire logic                          COMP_OUT,
   input  wire logic                          EXT_COUNT_PIN,
   output logic                               WAVE_OUT_A,
   output logic                               WAVE_OUT_B
);

   typedef struct packed {
      logic [15:0]      count;
      logic [15:0]      cmp_a_buf;
      logic [15:0]      cmp_a;
      logic [15:0]      cmp_b_buf;
      logic [15:0]      cmp_b;
      logic [15:0]      cap;
      logic [7:0]       temp;
      logic [7:0]       snap_hi;
      logic [7:0]       ctrl_a;
      logic [7:0]       ctrl_b;
      logic [3:0]       flags;
      logic [3:0]       mask;
      logic             power_off;
      logic             src_comp;
      logic             bottom;
      logic [PRE_W-1:0] pre;
      logic             wave_a;
      logic             wave_b;
      logic [7:0]       rdata;
      logic             ready;
      logic             slverr;
   } timer_state_t;

   timer_state_t st_reg;
   timer_state_t st_next;

   edge_if ev ();

   edge_front edge_front_i (
      .clk      (REF_CLK),
      .rst_n    (RSTN),
      .cap_pin  (CAPTURE_PIN),
      .comp_out (COMP_OUT),
      .ext_pin  (EXT_COUNT_PIN),
      .ev       (ev.front)
   );

   function automatic logic is_pwm(input logic [3:0] wgm);
      return (wgm == WGM_FAST8) || (wgm == WGM_FAST9) || (wgm == WGM_FAST10)
          || (wgm == WGM_FAST_CAP) || (wgm == WGM_FAST_CMPA);
   endfunction

   function automatic logic cap_is_top(input logic [3:0] wgm);
      return (wgm == WGM_CTC_CAP) || (wgm == WGM_FAST_CAP);
   endfunction

   // Low-byte reads that refill the holding register
   function automatic logic refills_temp(input logic [IDX_W-1:0] i);
      return (i == IDX_COUNT_L) || (i == IDX_CAP_L);
   endfunction

   function automatic logic [15:0] top_value(input logic [3:0]  wgm,
                                             input logic [15:0] cmpa,
                                             input logic [15:0] capv);
      logic [15:0] t;
      t = MAX_VAL;
      case (wgm)
         WGM_FAST8:     t = TOP_8BIT;
         WGM_FAST9:     t = TOP_9BIT;
         WGM_FAST10:    t = TOP_10BIT;
         WGM_CTC_CMPA:  t = cmpa;
         WGM_FAST_CMPA: t = cmpa;
         WGM_CTC_CAP:   t = capv;
         WGM_FAST_CAP:  t = capv;
         default:       t = MAX_VAL;
      endcase
      return t;
   endfunction

   function automatic logic tick_due(input logic [2:0]       cs,
                                     input logic [PRE_W-1:0] pre,
                                     input logic             ext);
      logic d;
      d = 1'b0;
      case (cs)
         CS_STOP:     d = 1'b0;
         CS_DIV1:     d = 1'b1;
         CS_DIV8:     d = &pre[2:0];
         CS_DIV64:    d = &pre[5:0];
         CS_DIV256:   d = &pre[7:0];
         CS_DIV1024:  d = &pre[9:0];
         default:     d = ext;
      endcase
      return d;
   endfunction

   function automatic logic wave_step(input logic       cur,
                                      input logic [1:0] com,
                                      input logic       pwm,
                                      input logic       match,
                                      input logic       at_bottom);
      logic w;
      w = cur;
      if (!pwm) begin
         if (match) begin
            case (com)
               COM_TOGGLE: w = ~cur;
               COM_CLEAR:  w = 1'b0;
               COM_SET:    w = 1'b1;
               default:    w = cur;
            endcase
         end
      end else if (com == COM_CLEAR) begin
         w = match ? 1'b0 : (at_bottom ? 1'b1 : cur);
      end else if (com == COM_SET) begin
         w = match ? 1'b1 : (at_bottom ? 1'b0 : cur);
      end
      return w;
   endfunction

   // Decode and control fields
   logic [IDX_W-1:0] idx;
   logic             mapped;
   logic             first_acc;
   logic [3:0]       wgm;
   logic [2:0]       cs;
   logic             pwm;
   logic [15:0]      top;
   logic             tick;
   logic             done;
   logic             wr;
   logic             rd;
   logic [7:0]       wb;

   assign idx    = PADDR[IDX_W+1:2];
   assign mapped = (idx <= IDX_MISC);
   assign wgm    = {st_reg.ctrl_b[CB_WGM_LSB+1:CB_WGM_LSB],
                    st_reg.ctrl_a[CA_WGM_LSB+1:CA_WGM_LSB]};
   assign cs     = st_reg.ctrl_b[CB_CS_LSB+2:CB_CS_LSB];
   assign pwm    = is_pwm(wgm);
   assign top    = top_value(wgm, st_reg.cmp_a, st_reg.cap);
   // Power-off freezes counting; registers stay accessible
   assign tick   = !st_reg.power_off && tick_due(cs, st_reg.pre, ev.ext_tick);
   assign done   = PSEL && PENABLE && st_reg.ready;
   assign wr     = done && PWRITE && mapped;
   assign rd     = done && !PWRITE && mapped;
   assign wb     = PWDATA[7:0];
   // First access cycle latches read data so it stands when ready rises
   assign first_acc = PSEL && PENABLE && !st_reg.ready;

   assign ev.noise_en = st_reg.ctrl_b[CB_NOISE];
   assign ev.cap_rise = st_reg.ctrl_b[CB_EDGE];
   assign ev.ext_rise = (cs == CS_EXT_RISE);
   assign ev.src_comp = st_reg.src_comp;

   assign PRDATA     = {24'h000000, st_reg.rdata};
   assign PREADY     = st_reg.ready;
   assign PSLVERR    = st_reg.slverr;
   assign WAVE_OUT_A = st_reg.wave_a;
   assign WAVE_OUT_B = st_reg.wave_b;

   always_comb begin
      logic       at_top;
      logic       match_a;
      logic       match_b;
      logic       cap_hit;
      logic       cnt_wr;
      logic [3:0] set_fl;
      logic [3:0] clr_fl;
      logic       wrap;
      at_top  = 1'b0;
      match_a = 1'b0;
      match_b = 1'b0;
      cap_hit = 1'b0;
      cnt_wr  = 1'b0;
      set_fl  = 4'h0;
      clr_fl  = 4'h0;
      wrap    = 1'b0;
      st_next = st_reg;

      // APB: first access cycle loads read data, second completes
      st_next.ready  = first_acc;
      st_next.slverr = first_acc && !mapped;
      if (first_acc) begin
         st_next.rdata = 8'h00;
         case (idx)
            IDX_CTRL_A:  st_next.rdata = st_reg.ctrl_a;
            IDX_CTRL_B:  st_next.rdata = st_reg.ctrl_b;
            IDX_COUNT_L: st_next.rdata = st_reg.count[7:0];
            IDX_COUNT_H: st_next.rdata = st_reg.temp;
            IDX_CMP_A_L: st_next.rdata = st_reg.cmp_a_buf[7:0];
            IDX_CMP_A_H: st_next.rdata = st_reg.cmp_a_buf[15:8];
            IDX_CMP_B_L: st_next.rdata = st_reg.cmp_b_buf[7:0];
            IDX_CMP_B_H: st_next.rdata = st_reg.cmp_b_buf[15:8];
            IDX_CAP_L:   st_next.rdata = st_reg.cap[7:0];
            IDX_CAP_H:   st_next.rdata = st_reg.temp;
            IDX_FLAGS:   st_next.rdata = {4'h0, st_reg.flags};
            IDX_MASK:    st_next.rdata = {4'h0, st_reg.mask};
            IDX_MISC:    st_next.rdata = {6'h00, st_reg.src_comp, st_reg.power_off};
            default:     st_next.rdata = 8'h00;
         endcase
         // High byte frozen with the low byte so the pair is one snapshot
         if (refills_temp(idx)) begin
            st_next.snap_hi = (idx == IDX_CAP_L) ? st_reg.cap[15:8] : st_reg.count[15:8];
         end
      end

      // Low-byte read completes: upper byte goes to holding register
      if (rd && refills_temp(idx)) begin
         st_next.temp = st_reg.snap_hi;
      end

      // Prescaler runs only while powered
      // Free-running divider, so the first divided tick after a start comes early
      if (!st_reg.power_off) begin
         st_next.pre = st_reg.pre + 1'b1;
      end

      // Counter, compare and capture
      at_top  = (st_reg.count == top);
      // Tick at top takes the counter to bottom
      wrap    = tick && at_top;
      match_a = tick && (st_reg.count == st_reg.cmp_a);
      match_b = tick && (st_reg.count == st_reg.cmp_b);
      cap_hit = ev.cap_evt && !cap_is_top(wgm);
      cnt_wr  = wr && (idx == IDX_COUNT_L);
      if (cnt_wr) begin
         st_next.count = {st_reg.temp, wb};
      end else if (tick) begin
         st_next.count = at_top ? BOTTOM_VAL : st_reg.count + 16'h0001;
      end
      // Bottom status tracks the value the counter takes next
      st_next.bottom = (st_next.count == BOTTOM_VAL);
      // Overflow at top in PWM modes, at maximum otherwise
      if (tick && (pwm ? at_top : (st_reg.count == MAX_VAL))) begin
         set_fl[FL_OVF] = 1'b1;
      end
      set_fl[FL_MA] = match_a;
      set_fl[FL_MB] = match_b;
      if (cap_hit) begin
         st_next.cap     = st_reg.count;
         set_fl[FL_CAP]  = 1'b1;
      end

      // Compare buffers reach the comparators at once or at top in PWM
      if (!pwm || wrap) begin
         st_next.cmp_a = st_reg.cmp_a_buf;
         st_next.cmp_b = st_reg.cmp_b_buf;
      end

      // Waveform outputs; compare A as top gives no PWM on channel A
      if (wgm == WGM_FAST_CMPA) begin
         st_next.wave_a = 1'b0;
      end else begin
         st_next.wave_a = wave_step(st_reg.wave_a, st_reg.ctrl_a[CA_COMA_LSB+1:CA_COMA_LSB],
                                    pwm, match_a, wrap);
      end
      st_next.wave_b = wave_step(st_reg.wave_b, st_reg.ctrl_a[CA_COMB_LSB+1:CA_COMB_LSB],
                                 pwm, match_b, wrap);

      // Register writes
      if (wr) begin
         case (idx)
            IDX_CTRL_A:  st_next.ctrl_a = wb;
            IDX_CTRL_B:  st_next.ctrl_b = wb;
            IDX_COUNT_H: st_next.temp = wb;
            IDX_CMP_A_H: st_next.temp = wb;
            IDX_CMP_B_H: st_next.temp = wb;
            IDX_CAP_H:   st_next.temp = wb;
            IDX_CMP_A_L: st_next.cmp_a_buf = {st_reg.temp, wb};
            IDX_CMP_B_L: st_next.cmp_b_buf = {st_reg.temp, wb};
            IDX_CAP_L: begin
               // Capture register is writable only while it sets the top
               if (cap_is_top(wgm)) begin
                  st_next.cap = {st_reg.temp, wb};
               end
            end
            IDX_FLAGS:   clr_fl = wb[3:0];
            IDX_MASK:    st_next.mask = wb[3:0];
            IDX_MISC: begin
               st_next.power_off = wb[MS_POWER_OFF];
               st_next.src_comp  = wb[MS_SRC_COMP];
            end
            default: begin
            end
         endcase
      end

      // Hardware set wins over a clear in the same cycle
      st_next.flags = (st_reg.flags & ~clr_fl) | set_fl;
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_reg           <= '0;
         st_reg.bottom    <= 1'b1;
         st_reg.power_off <= RST_POWER_OFF;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule

// ---- verif/timer16_properties.sv ----
`timescale 1ns/10ps
module timer16_properties
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic                         REF_CLK,
   input wire logic                         RSTN,
   // APB
   input wire logic                         PSEL,
   input wire logic                         PENABLE,
   input wire logic                         PWRITE,
   input wire logic [timer_pkg::ADDR_W-1:0] PADDR,
   input wire logic [timer_pkg::DATA_W-1:0] PWDATA,
   input wire logic [timer_pkg::DATA_W-1:0] PRDATA,
   input wire logic                         PREADY,
   input wire logic                         PSLVERR,
   // Pins
   input wire logic                         WAVE_OUT_A,
   input wire logic                         WAVE_OUT_B
);
   import timer_pkg::*;

   // Last byte written to control_reg_a, read back in full
   logic [7:0] ctrl_a_seen;

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctrl_a_seen <= 8'h00;
      end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR[7:2] == IDX_CTRL_A) begin
         ctrl_a_seen <= PWDATA[7:0];
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);

   property p_ready_next;
      PSEL && PENABLE && !PREADY |=> PREADY;
   endproperty
   a_ready_next: assert property (p_ready_next) else $error("late ready");
   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
   property p_ready_qual;
      PREADY |-> PSEL && PENABLE && $past(PENABLE);
   endproperty
   a_ready_qual: assert property (p_ready_qual) else $error("ready outside access");
   property p_err_map;
      PREADY |-> (PSLVERR == (PADDR[7:2] > IDX_MISC));
   endproperty
   a_err_map: assert property (p_err_map) else $error("error flag wrong");
   property p_err_only;
      PSLVERR |-> PREADY;
   endproperty
   a_err_only: assert property (p_err_only) else $error("error without ready");
   property p_upper_zero;
      PREADY |-> PRDATA[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper data not zero");
   property p_err_data;
      PSLVERR && !PWRITE |-> PRDATA == 32'h00000000;
   endproperty
   a_err_data: assert property (p_err_data) else $error("error read data");
   property p_rst_clear;
      $rose(RSTN) |-> PRDATA == 32'h00000000 && !WAVE_OUT_A && !WAVE_OUT_B;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("reset state");
   property p_ctrl_direct;
      PREADY && !PWRITE && PADDR[7:2] == IDX_CTRL_A |-> PRDATA[7:0] == ctrl_a_seen;
   endproperty
   a_ctrl_direct: assert property (p_ctrl_direct) else $error("control read");
endmodule

bind timer16 timer16_properties timer16_properties_i (
   .REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_B(WAVE_OUT_B));

// ---- verif/pin_driver.sv ----
`timescale 1ns/10ps
module pin_driver (
   // Clock
   input wire logic clk,
   // Pins toward the timer
   output logic     cap_pin,
   output logic     comp_out,
   output logic     ext_pin
);
   initial begin
      cap_pin = 1'b0;
      comp_out = 1'b0;
      ext_pin = 1'b0;
   end

   // Short lengths make spikes the filter must reject
   task automatic pulse_cap(input int len);
      @(posedge clk);
      cap_pin <= 1'b1;
      repeat (len) @(posedge clk);
      cap_pin <= 1'b0;
   endtask

   task automatic pulse_ext(input int n);
      repeat (n) begin
         @(posedge clk);
         ext_pin <= 1'b1;
         repeat (4) @(posedge clk);
         ext_pin <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule

// ---- verif/test_sixteen_bit_timer_core_access.sv ----
`timescale 1ns/10ps
module test_sixteen_bit_timer_core_access;
   import timer_pkg::*;

   logic        REF_CLK = 1'b0;
   logic        RSTN = 1'b0;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h00000000;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic        CAPTURE_PIN;
   logic        COMP_OUT;
   logic        EXT_COUNT_PIN;
   logic        WAVE_OUT_A;
   logic        WAVE_OUT_B;
   int          err_total = 0;
   int          compares = 0;

   always #2.5 REF_CLK = ~REF_CLK;

   timer16 timer16_i (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .CAPTURE_PIN(CAPTURE_PIN), .COMP_OUT(COMP_OUT),
      .EXT_COUNT_PIN(EXT_COUNT_PIN), .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_B(WAVE_OUT_B));
   pin_driver pin_driver_i (.clk(REF_CLK), .cap_pin(CAPTURE_PIN), .comp_out(COMP_OUT),
      .ext_pin(EXT_COUNT_PIN));

   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t flag got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request held until ready is seen high at an edge
   task automatic apb(input logic wr_en, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd_d, output logic err);
      int n;
      n = 0;
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= wr_en;
      PADDR <= {idx, 2'b00};
      PWDATA <= {24'h000000, wd};
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge REF_CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      if (PREADY !== 1'b1) err_total++;
      rd_d = PRDATA[7:0];
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic       e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      logic       e;
      apb(1'b0, idx, 8'h00, r, e);
      chk(r, exp);
   endtask

   task automatic rd_err(input logic [5:0] idx);
      logic [7:0] r;
      logic       e;
      apb(1'b0, idx, 8'h00, r, e);
      chkb(e, 1'b1);
      chk(r, 8'h00);
   endtask

   // No interrupts exist here, so a byte pair is never split
   task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
      wr(lo + 6'h01, v[15:8]);
      wr(lo, v[7:0]);
   endtask

   task automatic rd16(input logic [5:0] lo, input logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 6'h01, v[15:8]);
   endtask

   task automatic note(input string s);
      $display("test %s done", s);
   endtask

   initial begin
      #100000;
      err_total++;
      test_done();
   end

   initial begin
      repeat (2) @(posedge REF_CLK);
      RSTN <= 1'b1;
      for (int i = 0; i <= 12; i++) rd(6'(i), 8'h00);
      rd_err(6'h0D);
      rd_err(6'h3F);
      note("reset");
      wr(IDX_MISC, 8'h00);
      wr(IDX_CTRL_A, 8'hF1);
      rd(IDX_CTRL_A, 8'hF1);
      wr(IDX_CTRL_A, 8'h00);
      wr(IDX_CTRL_B, 8'h80);
      rd(IDX_CTRL_B, 8'h80);
      wr(IDX_MASK, 8'h0A);
      rd(IDX_MASK, 8'h0A);
      note("direct");
      wr16(IDX_COUNT_L, 16'h1234);
      repeat (50) @(posedge REF_CLK);
      rd16(IDX_COUNT_L, 16'h1234);
      wr(IDX_COUNT_H, 8'h56);
      rd16(IDX_COUNT_L, 16'h1234);
      wr16(IDX_CMP_A_L, 16'hABCD);
      wr(IDX_CMP_A_H, 8'h77);
      rd16(IDX_CMP_A_L, 16'hABCD);
      rd(IDX_COUNT_H, 8'h77);
      note("wide");
      wr16(IDX_CMP_B_L, 16'h0040);
      wr16(IDX_COUNT_L, 16'hFFF0);
      wr(IDX_FLAGS, 8'h0F);
      wr(IDX_CTRL_B, {5'h00, CS_DIV1});
      repeat (100) @(posedge REF_CLK);
      wr(IDX_CTRL_B, 8'h00);
      rd(IDX_FLAGS, 8'h05);
      wr(IDX_FLAGS, 8'h0F);
      rd(IDX_FLAGS, 8'h00);
      note("events");
      wr16(IDX_COUNT_L, 16'h2468);
      wr(IDX_CTRL_B, 8'hC0);
      pin_driver_i.pulse_cap(2);
      repeat (20) @(posedge REF_CLK);
      rd(IDX_FLAGS, 8'h00);
      pin_driver_i.pulse_cap(10);
      repeat (20) @(posedge REF_CLK);
      rd(IDX_FLAGS, 8'h08);
      rd16(IDX_CAP_L, 16'h2468);
      wr16(IDX_CAP_L, 16'h1111);
      rd16(IDX_CAP_L, 16'h2468);
      note("capture");
      wr(IDX_CTRL_B, {5'h00, CS_EXT_FALL});
      pin_driver_i.pulse_ext(5);
      repeat (10) @(posedge REF_CLK);
      wr(IDX_CTRL_B, {5'h00, CS_EXT_RISE});
      pin_driver_i.pulse_ext(5);
      repeat (10) @(posedge REF_CLK);
      wr(IDX_CTRL_B, 8'h00);
      rd16(IDX_COUNT_L, 16'h2472);
      note("external");
      wr16(IDX_CMP_A_L, 16'h0010);
      wr16(IDX_CMP_B_L, 16'h0020);
      wr16(IDX_COUNT_L, 16'h0000);
      wr(IDX_CTRL_A, 8'h70);
      wr(IDX_CTRL_B, {5'h00, CS_DIV1});
      repeat (40) @(posedge REF_CLK);
      wr(IDX_CTRL_B, 8'h00);
      chkb(WAVE_OUT_A, 1'b1);
      chkb(WAVE_OUT_B, 1'b1);
      rd(IDX_FLAGS, 8'h0E);
      wr(IDX_CTRL_A, 8'h73);
      wr(IDX_CTRL_B, 8'h18);
      repeat (2) @(posedge REF_CLK);
      chkb(WAVE_OUT_A, 1'b0);
      note("wave");
      test_done();
   end
endmodule
